/* include/tick_pulse_cfg.svh */
`ifndef TICK_PULSE_CFG_SVH
`define TICK_PULSE_CFG_SVH

// Register offsets (byte addresses)
`define TP_OFS_IRQ_ENABLE 16'h1024
`define TP_OFS_FLAGS 16'h1025
`define TP_OFS_CONTROL 16'h1026
`define TP_OFS_COUNT 16'h1027

// Flag and enable bit positions, shared by both registers
`define TP_BIT_MAIN_WRAP 7
`define TP_BIT_TICK 6
`define TP_BIT_PULSE_WRAP 5
`define TP_BIT_PULSE_EDGE 4

// Control field positions
`define TP_BIT_PORT7_DIR 7
`define TP_BIT_PULSE_EN 6
`define TP_BIT_PULSE_MODE 5
`define TP_BIT_PULSE_EDGE_SEL 4
`define TP_BIT_PORT3_DIR 3
`define TP_BIT_CAPCMP_SEL 2

// Reset values
`define TP_RST_IRQ_ENABLE 8'h00
`define TP_RST_FLAGS 8'h00
`define TP_RST_CONTROL 8'h00
`define TP_RST_COUNT 8'h00

// Timing: tick base division exponent and gated-mode divider
`define TP_TICK_BASE_LOG2 13
`define TP_GATE_DIV 7'h40
`define TP_GATE_DIV_LAST 6'h3F

`endif

/* include/tick_pulse_pkg.sv */
package tick_pulse_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [1:0] {
    RATE_2P13 = 2'h0,
    RATE_2P14 = 2'h1,
    RATE_2P15 = 2'h2,
    RATE_2P16 = 2'h3
  } tick_rate_t;

endpackage

/* design/periodic_tick_and_pulse_counter.sv */
// Overview of operation
// R1: Flag bits clear only where software writes a one; zeros leave them.
// R2: Main counter wrap flag sets when the 16-bit main counter wraps to zero.
// R3: Flag register bits 3:0 always read zero.
// R4: Rate field picks tick period of 2^13, 2^14, 2^15 or 2^16 cycles.
// R5: Tick base is bus clock over 2^13, independent of the main prescaler.
// R6: Tick divider runs freely; only reset restarts it, never flag clearing.
// R7: Each timeout sets the tick flag; interrupt requested if enabled.
// R8: After reset a full tick period passes before the first tick flag.
// R9: Software clears the tick flag by writing one to flag bit 6.
// R10: Upper enable bits pair with flags; both one requests an interrupt.
// R11: Tick enable low suppresses interrupt but the flag still sets.
// R12: Pulse counter is 8 bits, event or gated mode by mode bit.
// R13: Event mode counts pin edges; pin toggles no faster than clock/2.
// R14: Gated mode counts once per 64 cycles while pin is active.
// R15: Pulse counter readable and writable by software at any time.
// R16: Control register resets to zero: rate 00, pulse counting off.
// R17: Edge bit: falling/rising in event mode; inhibit low/high in gated mode.
// R18: Pulse wrap flag sets when the pulse counter rolls from FF to 00.
// R19: Pulse edge flag sets on each selected edge, whatever its enable; here only in event mode with pulse enable set.
// R20: Pulse system enable gates all pulse counting.
// R21: Tick divider is a free 16-bit count; timeout is the selected carry.
// R22: Pulse pin passes a two-stage synchroniser before any logic.
`timescale 1ns/1ps
`include "tick_pulse_cfg.svh"

module periodic_tick_and_pulse_counter
  import tick_pulse_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_main_counter_wrap,
  input wire logic i_pulse_input_pin,
  output logic o_irq,
  output logic o_port_bit7_direction,
  output logic o_port_bit3_direction,
  output logic o_capture_compare_select
);

  // Address decode used by both write and read paths
  function automatic logic hit(input logic [15:0] a, input logic [15:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [7:0] irq_en_q, irq_en_d;
  logic [7:0] flags_q, flags_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] count_q, count_d;
  logic [15:0] tick_div_q, tick_div_d;
  logic [5:0] gate_div_q, gate_div_d;
  logic [2:0] pin_sync_q, pin_sync_d;
  logic [7:0] rdata_q, rdata_d;

  logic tick_timeout;
  logic pin_s;
  logic pin_rise;
  logic pin_fall;
  logic sel_edge;
  logic gate_open;
  logic count_inc;
  logic count_wrap;
  logic [3:0] set_vec;
  tick_rate_t rate;

  // Synchroniser: stage 0 feeds only stage 1; stage 2 is the edge history
  always_comb begin
    pin_sync_d = {pin_sync_q[1:0], i_pulse_input_pin}; // see R22
  end

  assign pin_s = pin_sync_q[1];
  assign pin_rise = pin_sync_q[1] & ~pin_sync_q[2];
  assign pin_fall = ~pin_sync_q[1] & pin_sync_q[2];

  // Free tick divider; flag writes never touch it, so periods stay constant
  always_comb begin
    tick_div_d = tick_div_q + 16'h0001; // see R6
  end

  // Timeout when the low bits of the selected width all roll over
  always_comb begin
    rate = tick_rate_t'(ctrl_q[1:0]);
    case (rate) // see R4
      RATE_2P13: tick_timeout = &tick_div_q[`TP_TICK_BASE_LOG2-1:0]; // see R5
      RATE_2P14: tick_timeout = &tick_div_q[13:0];
      RATE_2P15: tick_timeout = &tick_div_q[14:0];
      RATE_2P16: tick_timeout = &tick_div_q[15:0]; // see R21
      default: tick_timeout = 1'b0;
    endcase
  end

  // Gated-mode divider runs freely so the time base never drifts
  always_comb begin
    gate_div_d = gate_div_q + 6'h01; // see R14
  end

  // Counting condition from enable, mode and edge select
  always_comb begin
    sel_edge = ctrl_q[`TP_BIT_PULSE_EDGE_SEL] ? pin_rise : pin_fall; // see R17
    gate_open = ctrl_q[`TP_BIT_PULSE_EDGE_SEL] ? ~pin_s : pin_s; // see R17
    if (!ctrl_q[`TP_BIT_PULSE_EN]) begin
      count_inc = 1'b0; // see R20
    end else if (ctrl_q[`TP_BIT_PULSE_MODE]) begin
      count_inc = gate_open && (gate_div_q == `TP_GATE_DIV_LAST); // see R14
    end else begin
      count_inc = sel_edge; // see R13
    end
  end

  // Pulse counter; a software write wins over a coincident increment
  always_comb begin
    count_wrap = 1'b0;
    count_d = count_q;
    if (i_wr && hit(i_addr, `TP_OFS_COUNT)) begin
      count_d = i_wdata; // see R15
    end else if (count_inc) begin
      count_d = count_q + 8'h01; // see R12
      count_wrap = (count_q == 8'hFF); // see R18
    end
  end

  // Flag set sources; edge flag needs the enable and event mode
  assign set_vec = {
    i_main_counter_wrap, // see R2
    tick_timeout, // see R7, R11
    count_wrap,
    ctrl_q[`TP_BIT_PULSE_EN] & ~ctrl_q[`TP_BIT_PULSE_MODE] & sel_edge // see R19
  };

  // Flags: write-one clears, but a same-cycle set survives
  always_comb begin
    flags_d = flags_q;
    if (i_wr && hit(i_addr, `TP_OFS_FLAGS)) begin
      flags_d[7:4] = flags_q[7:4] & ~i_wdata[7:4]; // see R1
    end
    flags_d[7:4] = flags_d[7:4] | set_vec;
    flags_d[3:0] = 4'h0; // see R3
  end

  // Control and enable registers
  always_comb begin
    irq_en_d = irq_en_q;
    ctrl_d = ctrl_q;
    if (i_wr && hit(i_addr, `TP_OFS_IRQ_ENABLE)) begin
      irq_en_d = {i_wdata[7:4], 2'h0, i_wdata[1:0]};
    end
    if (i_wr && hit(i_addr, `TP_OFS_CONTROL)) begin
      ctrl_d = i_wdata;
    end
  end

  // Read data in the cycle after the strobe; unmapped reads give zero
  always_comb begin
    rdata_d = 8'h00;
    if (i_rd) begin
      if (hit(i_addr, `TP_OFS_IRQ_ENABLE)) begin
        rdata_d = irq_en_q;
      end else if (hit(i_addr, `TP_OFS_FLAGS)) begin
        rdata_d = {flags_q[7:4], 4'h0}; // see R3
      end else if (hit(i_addr, `TP_OFS_CONTROL)) begin
        rdata_d = ctrl_q;
      end else if (hit(i_addr, `TP_OFS_COUNT)) begin
        rdata_d = count_q; // see R15
      end
    end
  end

  // Registers; tick divider starts at zero so the first tick is a full period
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      irq_en_q <= `TP_RST_IRQ_ENABLE;
      flags_q <= `TP_RST_FLAGS;
      ctrl_q <= `TP_RST_CONTROL; // see R16
      count_q <= `TP_RST_COUNT;
      tick_div_q <= 16'h0000; // see R8
      gate_div_q <= 6'h00;
      pin_sync_q <= 3'h0;
      rdata_q <= 8'h00;
    end else begin
      irq_en_q <= irq_en_d;
      flags_q <= flags_d;
      ctrl_q <= ctrl_d;
      count_q <= count_d;
      tick_div_q <= tick_div_d;
      gate_div_q <= gate_div_d;
      pin_sync_q <= pin_sync_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq = |(flags_q[7:4] & irq_en_q[7:4]); // see R10
  assign o_port_bit7_direction = ctrl_q[`TP_BIT_PORT7_DIR];
  assign o_port_bit3_direction = ctrl_q[`TP_BIT_PORT3_DIR];
  assign o_capture_compare_select = ctrl_q[`TP_BIT_CAPCMP_SEL];

  // Checker helper: cycles since reset or the last timeout, kept apart
  // from the divider so a divider fault cannot hide behind itself
  logic [16:0] since_tick_q, since_tick_d;

  always_comb begin
    since_tick_d = tick_timeout ? 17'h00000 : since_tick_q + 17'h00001;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      since_tick_q <= 17'h00000;
    end else begin
      since_tick_q <= since_tick_d;
    end
  end

  chk_tick_sets_flag: assert property ( // see R7
    @(posedge i_core_clk) disable iff (i_rst)
    tick_timeout |=> flags_q[`TP_BIT_TICK])
    else $error("tick timeout did not set tick flag");

  // Rate 00 must time out one base period after the last timeout
  chk_tick_period_fixed: assert property ( // see R4
    @(posedge i_core_clk) disable iff (i_rst)
    (ctrl_q[1:0] == 2'h0 && since_tick_q == 17'h01FFF) |-> tick_timeout)
    else $error("tick period mismatch");

  chk_first_tick_full: assert property ( // see R8
    @(posedge i_core_clk) disable iff (i_rst)
    tick_timeout |-> since_tick_q[12:0] == 13'h1FFF)
    else $error("tick fired before a full period");

  chk_flag_w1c: assert property ( // see R1
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `TP_OFS_FLAGS && !i_wdata[`TP_BIT_TICK]
      && flags_q[`TP_BIT_TICK]) |=> flags_q[`TP_BIT_TICK])
    else $error("zero write cleared tick flag");

  chk_flag_clear: assert property ( // see R9
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `TP_OFS_FLAGS && i_wdata[`TP_BIT_TICK] && !tick_timeout)
      |=> !flags_q[`TP_BIT_TICK])
    else $error("tick flag not cleared by one write");

  chk_low_flags_zero: assert property ( // see R3
    @(posedge i_core_clk) disable iff (i_rst)
    (i_rd && i_addr == `TP_OFS_FLAGS) |=> o_rdata[3:0] == 4'h0)
    else $error("low flag bits read nonzero");

  chk_irq_pairing: assert property ( // see R10
    @(posedge i_core_clk) disable iff (i_rst)
    (flags_q[`TP_BIT_TICK] && !irq_en_q[`TP_BIT_TICK] && irq_en_q[7] == 1'b0
      && irq_en_q[5:4] == 2'h0) |-> !o_irq)
    else $error("interrupt without enabled flag");

  chk_main_wrap: assert property ( // see R2
    @(posedge i_core_clk) disable iff (i_rst)
    i_main_counter_wrap |=> flags_q[`TP_BIT_MAIN_WRAP])
    else $error("main wrap flag not set");

  chk_pulse_wrap: assert property ( // see R18
    @(posedge i_core_clk) disable iff (i_rst)
    (count_inc && count_q == 8'hFF && !i_wr)
      |=> (count_q == 8'h00 && flags_q[`TP_BIT_PULSE_WRAP]))
    else $error("pulse wrap not flagged");

  chk_pulse_disabled: assert property ( // see R20
    @(posedge i_core_clk) disable iff (i_rst)
    (!ctrl_q[`TP_BIT_PULSE_EN] && !i_wr) |=> $stable(count_q))
    else $error("pulse counted while disabled");

  chk_event_edge: assert property ( // see R13
    @(posedge i_core_clk) disable iff (i_rst)
    (ctrl_q[6:4] == 3'b101 && pin_rise && !i_wr)
      |=> count_q == $past(count_q) + 8'h01)
    else $error("rising edge not counted");

  // Pulse counter checks; a same-cycle software write wins, so it is excluded
  chk_fall_counted: assert property ( // see R17
    @(posedge i_core_clk) disable iff (i_rst)
    (ctrl_q[6:4] == 3'b100 && pin_fall && !i_wr)
      |=> count_q == $past(count_q) + 8'h01)
    else $error("falling edge not counted");

  chk_edge_flag_set: assert property ( // see R19
    @(posedge i_core_clk) disable iff (i_rst)
    (ctrl_q[6:4] == 3'b101 && pin_rise) |=> flags_q[`TP_BIT_PULSE_EDGE])
    else $error("pulse edge flag not set");

  chk_gated_step: assert property ( // see R14
    @(posedge i_core_clk) disable iff (i_rst)
    (ctrl_q[6:4] == 3'b110 && pin_s && gate_div_q == `TP_GATE_DIV_LAST && !i_wr)
      |=> count_q == $past(count_q) + 8'h01)
    else $error("gated period not counted");

  chk_gated_hold: assert property ( // see R14
    @(posedge i_core_clk) disable iff (i_rst)
    (ctrl_q[6:5] == 2'b11 && gate_div_q != `TP_GATE_DIV_LAST && !i_wr)
      |=> $stable(count_q))
    else $error("gated count between periods");

  chk_gate_inhibit: assert property ( // see R17
    @(posedge i_core_clk) disable iff (i_rst)
    (ctrl_q[6:4] == 3'b111 && pin_s && !i_wr) |=> $stable(count_q))
    else $error("count while pin inhibits");

  chk_count_write: assert property ( // see R15
    @(posedge i_core_clk) disable iff (i_rst)
    (i_wr && i_addr == `TP_OFS_COUNT) |=> count_q == $past(i_wdata))
    else $error("count write lost");

  // Tick and interrupt checks
  chk_tick_polled: assert property ( // see R11
    @(posedge i_core_clk) disable iff (i_rst)
    (tick_timeout && irq_en_q[7:4] == 4'h0 && !(i_wr && i_addr == `TP_OFS_IRQ_ENABLE))
      |=> (flags_q[`TP_BIT_TICK] && !o_irq))
    else $error("masked tick flag or interrupt wrong");

  chk_tick_irq: assert property ( // see R7
    @(posedge i_core_clk) disable iff (i_rst)
    (flags_q[`TP_BIT_TICK] && irq_en_q[`TP_BIT_TICK]) |-> o_irq)
    else $error("tick interrupt not requested");

  // Synchroniser latency and reset state; the guard skips history
  // that was sampled while reset was still held
  chk_pin_sync: assert property ( // see R22
    @(posedge i_core_clk) disable iff (i_rst)
    !$past(i_rst, 2) |-> pin_s == $past(i_pulse_input_pin, 2))
    else $error("pulse pin not two stages late");

  chk_ctrl_reset: assert property ( // see R16
    @(posedge i_core_clk) disable iff (i_rst)
    $fell(i_rst) |-> (ctrl_q == 8'h00 && flags_q == 8'h00))
    else $error("control or flags not zero after reset");

  // Covers for the main scenarios
  cov_tick: cover property (@(posedge i_core_clk) disable iff (i_rst) tick_timeout);
  cov_irq: cover property (@(posedge i_core_clk) disable iff (i_rst) o_irq);
  cov_pulse_wrap: cover property (@(posedge i_core_clk) disable iff (i_rst) count_wrap);
  cov_gated: cover property (@(posedge i_core_clk) disable iff (i_rst)
    count_inc && ctrl_q[`TP_BIT_PULSE_MODE]);
  cov_event_fall: cover property (@(posedge i_core_clk) disable iff (i_rst)
    count_inc && pin_fall && !ctrl_q[`TP_BIT_PULSE_EDGE_SEL]);

endmodule

/* test/pulse_source.sv */
`timescale 1ns/1ps
// Far-side pulse pin driver: idle level plus bursts of full pulses
module pulse_source (
  input wire logic i_core_clk,
  input wire logic i_level,
  input wire logic i_go,
  input wire logic [7:0] i_pulses,
  output logic o_pin
);
  logic [7:0] left_q = 8'h00;
  logic [1:0] ph_q = 2'h0;
  logic tog_q = 1'b0;

  // Toggle every 4 cycles, far slower than clock/2
  always_ff @(posedge i_core_clk) begin
    ph_q <= ph_q + 2'h1;
    if (i_go) begin
      left_q <= i_pulses;
    end else if (ph_q == 2'h3 && left_q != 8'h00) begin
      tog_q <= ~tog_q;
      if (tog_q) begin
        left_q <= left_q - 8'h01;
      end
    end
  end

  assign o_pin = i_level ^ tog_q;
endmodule

/* test/testbench.sv */
`timescale 1ns/1ps
`include "tick_pulse_cfg.svh"
module testbench;
  import tick_pulse_pkg::*;
  logic i_core_clk, i_rst, i_wr, i_rd, i_main_counter_wrap, lvl, go, o_irq, pin;
  logic [15:0] i_addr;
  byte_t i_wdata, o_rdata, rv;
  logic [7:0] npul;
  wire [2:0] dirs;
  int fails = 0, num_checks = 0, cyc = 0, p, w;

  periodic_tick_and_pulse_counter periodic_tick_and_pulse_counter_inst (
    .i_core_clk(i_core_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_main_counter_wrap(i_main_counter_wrap),
    .i_pulse_input_pin(pin), .o_irq(o_irq), .o_port_bit7_direction(dirs[2]),
    .o_port_bit3_direction(dirs[1]), .o_capture_compare_select(dirs[0]));
  pulse_source pulse_source_inst (
    .i_core_clk(i_core_clk), .i_level(lvl), .i_go(go), .i_pulses(npul), .o_pin(pin));

  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  // Edges since reset release, the time base of every tick expectation
  always @(posedge i_core_clk) if (!i_rst) cyc <= cyc + 1;

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [15:0] a, input byte_t d);
    @(posedge i_core_clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
    #1; // Let the written register settle before any direct compare
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input byte_t e, input string nm);
    @(posedge i_core_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_core_clk);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
    chk(nm, e, rv);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge i_core_clk);
  endtask
  task automatic wait_to(input int n);
    while (cyc < n) @(posedge i_core_clk);
  endtask
  task automatic burst(input logic [7:0] n);
    @(posedge i_core_clk);
    npul <= n; go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    idle(10 * n + 10);
  endtask

  initial begin
    i_rst = 1'b1; i_wr = 1'b0; i_rd = 1'b0; i_addr = 16'h0000; i_wdata = 8'h00;
    i_main_counter_wrap = 1'b0; lvl = 1'b0; go = 1'b0; npul = 8'h00;
    idle(20);
    i_rst <= 1'b0;
    rchk(`TP_OFS_IRQ_ENABLE, 8'h00, "enable reset");
    rchk(`TP_OFS_FLAGS, 8'h00, "flags reset");
    rchk(`TP_OFS_CONTROL, 8'h00, "control reset");
    rchk(16'h1030, 8'h00, "unmapped");
    wr(`TP_OFS_CONTROL, 8'h8C);
    rchk(`TP_OFS_CONTROL, 8'h8C, "control rw");
    chk("direction bits", 8'h07, {5'h00, dirs});
    wr(`TP_OFS_CONTROL, 8'h00);
    chk("direction off", 8'h00, {5'h00, dirs});
    // Main counter wrap, then a write of zero in its position
    @(posedge i_core_clk) i_main_counter_wrap <= 1'b1;
    @(posedge i_core_clk) i_main_counter_wrap <= 1'b0;
    rchk(`TP_OFS_FLAGS, 8'h80, "main wrap");
    wr(`TP_OFS_FLAGS, 8'h7F);
    rchk(`TP_OFS_FLAGS, 8'h80, "zero write");
    wr(`TP_OFS_IRQ_ENABLE, 8'h80);
    chk("irq main", 8'h01, {7'h00, o_irq});
    wr(`TP_OFS_FLAGS, 8'h80);
    rchk(`TP_OFS_FLAGS, 8'h00, "main clear");
    chk("irq off", 8'h00, {7'h00, o_irq});
    // Event mode rising edges across the FF to 00 rollover
    wr(`TP_OFS_COUNT, 8'hFD);
    wr(`TP_OFS_CONTROL, 8'h50);
    burst(8'h05);
    rchk(`TP_OFS_COUNT, 8'h02, "event count");
    rchk(`TP_OFS_FLAGS, 8'h30, "pulse flags");
    wr(`TP_OFS_IRQ_ENABLE, 8'h20);
    chk("irq pulse wrap", 8'h01, {7'h00, o_irq});
    wr(`TP_OFS_IRQ_ENABLE, 8'h00);
    // Falling edge select: a rise alone must not count
    wr(`TP_OFS_CONTROL, 8'h40);
    lvl <= 1'b1;
    idle(10);
    rchk(`TP_OFS_COUNT, 8'h02, "rise ignored");
    lvl <= 1'b0;
    idle(10);
    rchk(`TP_OFS_COUNT, 8'h03, "fall counted");
    wr(`TP_OFS_CONTROL, 8'h00);
    burst(8'h04);
    rchk(`TP_OFS_COUNT, 8'h03, "disabled");
    // Gated mode: ten divider periods with the pin high
    wr(`TP_OFS_COUNT, 8'h00);
    wr(`TP_OFS_CONTROL, 8'h60);
    lvl <= 1'b1;
    idle(640);
    lvl <= 1'b0;
    idle(10);
    rchk(`TP_OFS_COUNT, 8'h0A, "gated count");
    // Raise the inhibiting level first, then clear, so no open cycle leaks
    wr(`TP_OFS_CONTROL, 8'h70);
    lvl <= 1'b1;
    idle(4);
    wr(`TP_OFS_COUNT, 8'h00);
    idle(200);
    rchk(`TP_OFS_COUNT, 8'h00, "gate inhibit");
    lvl <= 1'b0;
    wr(`TP_OFS_CONTROL, 8'h00);
    wr(`TP_OFS_FLAGS, 8'hF0);
    // First tick only after one whole period from reset
    wait_to(8170);
    rchk(`TP_OFS_FLAGS, 8'h00, "tick early");
    wait_to(8210);
    rchk(`TP_OFS_FLAGS, 8'h40, "tick flag");
    chk("irq masked", 8'h00, {7'h00, o_irq});
    wr(`TP_OFS_IRQ_ENABLE, 8'h40);
    chk("irq tick", 8'h01, {7'h00, o_irq});
    wr(`TP_OFS_FLAGS, 8'h40);
    rchk(`TP_OFS_FLAGS, 8'h00, "tick clear");
    wr(`TP_OFS_IRQ_ENABLE, 8'h00);
    wait_to(16370);
    rchk(`TP_OFS_FLAGS, 8'h00, "period early");
    wait_to(16410);
    rchk(`TP_OFS_FLAGS, 8'h40, "period kept");
    // Each slower rate: no tick at the half period; tick at the full one for rates 1 and 2 only
    for (int r = 1; r < 4; r++) begin
      p = 1 << (13 + r);
      wr(`TP_OFS_CONTROL, r[7:0]);
      wr(`TP_OFS_FLAGS, 8'h40);
      w = (cyc / p) * p + p / 2;
      if (w < cyc) w += p;
      wait_to(w + 20);
      rchk(`TP_OFS_FLAGS, 8'h00, "rate half");
      if (w + p / 2 < 99000) begin
        wait_to(w + p / 2 + 20);
        rchk(`TP_OFS_FLAGS, 8'h40, "rate full");
      end
    end
    end_of_test();
  end

  // Main path ends near cycle 98350; a hang stops just short of 100000
  initial begin
    idle(99800);
    fails++;
    end_of_test();
  end
endmodule
